//--- rbs_board.sv
// Board model: reset circuit and strap drivers.
// Assumes the bench sets strap levels before reset release.
`timescale 1ns/10ps
module rbs_board (
  input wire clk,
  input wire srst,
  input wire [2:0] strap,
  input wire oe_n,
  input wire o,
  output wire program_store_strobe_pin,
  output wire ea,
  output wire ale
);
  reg drv_r = 1'b1; // Straps driven
  // Let go of straps one edge after release
  always @(posedge clk)
    drv_r <= srst;
  // Pull-up on the strobe pin once released
  assign program_store_strobe_pin = !oe_n ? o : (drv_r ? strap[2] : 1'b1);
  assign ea = drv_r ? strap[1] : ~strap[1];
  assign ale = drv_r ? strap[0] : 1'b1; // Floats high
endmodule

//--- rbs_defs.vh
// Constants for the reset boot selection block.
// Assumes inclusion by bare name from the design files.
`ifndef RBS_DEFS_VH
`define RBS_DEFS_VH
`define RBS_FLASH_CTRL_FORCED 8'h00
`define RBS_FLASH_CTRL_NORMAL 8'hF0
`define RBS_PC_BOOT 16'hF800
`define RBS_PC_USER 16'h0000
`define RBS_USER_VECTOR_DEF 8'hFC
`define RBS_SEC_ERASED 8'hFF
`define RBS_SEC_SHIPPED 8'hBF
`define RBS_SEC_SPEED_BIT 7
`define RBS_SEC_JUMP_BIT 6
`define RBS_SEC_SW_MASK 8'hF0
`define RBS_SEC_LOCK_MASK 8'h07
`define RBS_ROW_MAKER 8'h30
`define RBS_ROW_FAMILY 8'h31
`define RBS_ROW_MEMTYPE 8'h60
`define RBS_ROW_REVISION 8'h61
`define RBS_SEL_BOOT_ROW 2'h0
`define RBS_SEL_SEC 2'h1
`define RBS_SEL_VECTOR 2'h2
`define RBS_SEL_SPARE 2'h3
`endif

//--- rbs_reset_boot_selection.v
// Top of the reset boot selection: config bytes, boot decision.
// Assumes straps synchronous to CLK, config bytes kept outside reset.
// Operating notes:
// - Straps are looked at once, on the first CE edge with SRST low.
// - Boot outputs settle on the next CE edge after that.
// - Fetch stays off, and the strobe pin undriven, until then.
// - Config bytes live outside reset, like the flash cells.
// - One-time shipped image loads on the first CE edge.
// - Reset also waits for CE; a frozen block ignores reset.
// - Software writes reach only the upper security nibble.
// - Parallel mode reaches all eight security bits.
// - Parallel erase beats a write in the same cycle.
// - In-system erase never touches the security byte.
// - Identity copies are parameters, read-only.
// - Unknown identity row addresses read as zero.
// - Read data is registered and holds between reads.
// - Strobe output passes the core strobe once fetching.
// Hazards:
// - Board must let go of the strobe pin after release.
// - A grounded strobe at power-on, with access and latch high, forces the loader.
// - Reserved bits 5:3 read as stored in parallel mode.
// - Straps that move after release are ignored on purpose.
// - A reset that spans no CE edge misses the sampler.
// - CE low during release stretches the whole sequence.
// Config select map:
// - Select 0: identity copy row, addressed by CFG_ADDR.
// - Select 1: security byte, masked by mode.
// - Select 2: user boot vector byte.
// - Select 3: spare byte, or status byte when CFG_ADDR[0] set.
`timescale 1ns/10ps
`include "rbs_defs.vh"
module rbs_reset_boot_selection #(
  parameter [7:0] MAKER_CODE = 8'h11, // Arbitrary value
  parameter [7:0] FAMILY_CODE = 8'h22, // Arbitrary value
  parameter [7:0] MEMTYPE_CODE = 8'h33, // Arbitrary value
  parameter [7:0] REVISION_CODE = 8'h44 // Arbitrary value
) (
  // Clocking and freeze
  input wire CLK,
  input wire SRST,
  input wire CE,
  // Strap pins
  input wire PROGRAM_STORE_STROBE_PIN_I,
  output wire PROGRAM_STORE_STROBE_PIN_O,
  output wire PROGRAM_STORE_STROBE_PIN_OE_N,
  input wire EXTERNAL_ACCESS_PIN,
  input wire ADDR_LATCH_PIN,
  // Core side strobe
  input wire CORE_STROBE,
  // Config byte access
  input wire CFG_RD,
  input wire CFG_WR,
  input wire [1:0] CFG_SEL,
  input wire [7:0] CFG_ADDR,
  input wire [7:0] CFG_WDATA,
  output reg [7:0] CFG_RDATA,
  // Programming modes
  input wire PARALLEL_MODE,
  input wire PARALLEL_ERASE,
  input wire ISP_ERASE,
  // Boot results
  output reg BOOT_SPACE_ENABLE,
  output reg [7:0] FLASH_CONTROL,
  output reg [15:0] START_PC,
  output wire DOUBLE_SPEED_SELECT,
  output wire [2:0] LOCK_FIELD,
  output wire FETCH_ENABLE
);
  wire forced_boot; // Strap combination caught at release
  wire release_pulse; // One cycle after reset falls
  reg [7:0] sec_byte_r; // Security configuration byte
  reg [7:0] user_vector_r; // User boot vector byte
  reg [7:0] spare_byte_r; // Customer spare byte
  reg [7:0] boot_status_byte_r; // Customer boot status byte
  reg boot_ready_r; // Boot state loaded
  reg sec_init_r; // Shipped image already applied
  reg [7:0] cfg_rdata_nxt; // Read mux result
  reg [7:0] sec_nxt; // Next security byte
  wire [7:0] sw_mask; // Software-reachable bits
  wire [7:0] sec_wr_mask; // Bits a write may change now
  genvar gi; // Bit index

  // Write strobe aimed at one config byte
  function sel_hit;
    input wr;
    input [1:0] sel;
    input [1:0] target;
    begin
      sel_hit = wr && (sel == target);
    end
  endfunction

  assign sw_mask = `RBS_SEC_SW_MASK;
  // Per bit: software nibble always, all bits in parallel mode
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_sec_mask
      assign sec_wr_mask[gi] = sw_mask[gi] | PARALLEL_MODE;
    end
  endgenerate

  // Decode identity copy address
  function [7:0] row_lookup;
    input [7:0] addr;
    begin
      case (addr)
        `RBS_ROW_MAKER: row_lookup = MAKER_CODE;
        `RBS_ROW_FAMILY: row_lookup = FAMILY_CODE;
        `RBS_ROW_MEMTYPE: row_lookup = MEMTYPE_CODE;
        `RBS_ROW_REVISION: row_lookup = REVISION_CODE;
        default: row_lookup = 8'h00;
      endcase
    end
  endfunction

  // Strap capture at reset release
  rbs_strap_sampler u_sampler (
    .clk(CLK),
    .srst(SRST),
    .ce(CE),
    .store_strobe_in(PROGRAM_STORE_STROBE_PIN_I),
    .ext_access_in(EXTERNAL_ACCESS_PIN),
    .addr_latch_in(ADDR_LATCH_PIN),
    .forced_boot_r(forced_boot),
    .release_pulse_r(release_pulse)
  );

  // Strobe pin is input during reset, driven once fetching
  assign PROGRAM_STORE_STROBE_PIN_O = CORE_STROBE;
  assign PROGRAM_STORE_STROBE_PIN_OE_N = ~boot_ready_r;
  // Mode fields from the byte; speed select is bit 7 inverted
  assign DOUBLE_SPEED_SELECT = ~sec_byte_r[`RBS_SEC_SPEED_BIT];
  assign LOCK_FIELD = sec_byte_r[2:0];
  assign FETCH_ENABLE = boot_ready_r;

  // Next security byte from erase and writes
  always @*
  begin
    sec_nxt = sec_byte_r;
    if (PARALLEL_MODE && PARALLEL_ERASE)
      sec_nxt = `RBS_SEC_ERASED;
    else if (ISP_ERASE)
      sec_nxt = sec_byte_r;
    else if (sel_hit(CFG_WR, CFG_SEL, `RBS_SEL_SEC))
    begin
      // Merge written bits under the reach mask
      sec_nxt = (CFG_WDATA & sec_wr_mask) | (sec_byte_r & ~sec_wr_mask);
    end
  end

  // Config bytes: nonvolatile, untouched by reset
  always @(posedge CLK)
  begin
    if (CE)
    begin
      if (!sec_init_r)
      begin
        // Shipped image: bootloader present, jump bit zero
        sec_byte_r <= `RBS_SEC_SHIPPED;
        user_vector_r <= `RBS_USER_VECTOR_DEF;
        spare_byte_r <= `RBS_SEC_ERASED;
        boot_status_byte_r <= `RBS_SEC_ERASED;
        sec_init_r <= 1'b1;
      end
      else
      begin
        sec_byte_r <= sec_nxt;
        if (sel_hit(CFG_WR, CFG_SEL, `RBS_SEL_VECTOR))
          user_vector_r <= CFG_WDATA;
        if (sel_hit(CFG_WR, CFG_SEL, `RBS_SEL_SPARE))
        begin
          if (CFG_ADDR[0])
            boot_status_byte_r <= CFG_WDATA;
          else
            spare_byte_r <= CFG_WDATA;
        end
      end
    end
  end

  // Sim start for the one-time image flag
  initial sec_init_r = 1'b0;

  // Read mux
  always @*
  begin
    cfg_rdata_nxt = 8'h00;
    case (CFG_SEL)
      `RBS_SEL_BOOT_ROW: cfg_rdata_nxt = row_lookup(CFG_ADDR);
      `RBS_SEL_SEC:
      begin
        if (PARALLEL_MODE)
          cfg_rdata_nxt = sec_byte_r; // Reserved bits read as stored
        else
          cfg_rdata_nxt = sec_byte_r & `RBS_SEC_SW_MASK;
      end
      `RBS_SEL_VECTOR: cfg_rdata_nxt = user_vector_r;
      `RBS_SEL_SPARE: cfg_rdata_nxt = CFG_ADDR[0] ? boot_status_byte_r : spare_byte_r;
      default: cfg_rdata_nxt = 8'h00;
    endcase
  end

  // Registered read data, frozen while CE is low
  always @(posedge CLK)
  begin
    if (CE)
    begin
      if (SRST)
        // Cleared under reset
        CFG_RDATA <= 8'h00;
      else if (CFG_RD)
        // Captured on the read edge, held until the next read
        CFG_RDATA <= cfg_rdata_nxt;
    end
  end

  // Boot outcome:
  // - Forced straps: control 00h, start F800h, any jump bit.
  // - No straps, jump one: control F0h, start 0000h.
  // - No straps, jump zero: control F0h, start F800h.
  // - Boot enable always copies the jump bit.
  // Boot decision one CE edge after the straps were caught
  always @(posedge CLK)
  begin
    if (CE)
    begin
      if (SRST)
      begin
        // Held in reset: no fetch, user defaults
        BOOT_SPACE_ENABLE <= 1'b0;
        FLASH_CONTROL <= `RBS_FLASH_CTRL_NORMAL;
        START_PC <= `RBS_PC_USER;
        boot_ready_r <= 1'b0;
      end
      else if (release_pulse)
      begin
        // Load all boot state and open fetch in the same edge
        BOOT_SPACE_ENABLE <= sec_byte_r[`RBS_SEC_JUMP_BIT];
        boot_ready_r <= 1'b1;
        if (forced_boot)
        begin
          // Bootloader whatever the jump bit
          FLASH_CONTROL <= `RBS_FLASH_CTRL_FORCED;
          START_PC <= `RBS_PC_BOOT;
        end
        else
        begin
          // Normal start, jump bit picks the space
          FLASH_CONTROL <= `RBS_FLASH_CTRL_NORMAL;
          if (sec_byte_r[`RBS_SEC_JUMP_BIT])
            // User application
            START_PC <= `RBS_PC_USER;
          else
            // Bootloader
            START_PC <= `RBS_PC_BOOT;
        end
      end
    end
  end
endmodule

//--- rbs_reset_boot_selection_bench.sv
// Bench for boot selection and configuration bytes.
// Assumes board model and bound checker.
`timescale 1ns/10ps
module rbs_reset_boot_selection_bench;
  reg CLK = 1'h0, SRST = 1'h1, CE = 1'h1, CORE_STROBE = 1'h0, CFG_RD = 1'h0, CFG_WR = 1'h0;
  reg PARALLEL_MODE = 1'h0, PARALLEL_ERASE = 1'h0, ISP_ERASE = 1'h0;
  reg [1:0] CFG_SEL = 2'h0;
  reg [7:0] CFG_ADDR = 8'h00, CFG_WDATA = 8'h00;
  reg [2:0] strap = 3'h7; // Strobe, access, latch; strobe high at power-on
  wire PROGRAM_STORE_STROBE_PIN_I, PROGRAM_STORE_STROBE_PIN_O, PROGRAM_STORE_STROBE_PIN_OE_N;
  wire EXTERNAL_ACCESS_PIN, ADDR_LATCH_PIN, BOOT_SPACE_ENABLE, DOUBLE_SPEED_SELECT, FETCH_ENABLE;
  wire [7:0] CFG_RDATA, FLASH_CONTROL;
  wire [15:0] START_PC;
  wire [2:0] LOCK_FIELD;
  int n_mismatch = 0, n_checks = 0;
  rbs_reset_boot_selection rbs_reset_boot_selection_i (
    .CLK(CLK), .SRST(SRST), .CE(CE),
    .PROGRAM_STORE_STROBE_PIN_I(PROGRAM_STORE_STROBE_PIN_I),
    .PROGRAM_STORE_STROBE_PIN_O(PROGRAM_STORE_STROBE_PIN_O),
    .PROGRAM_STORE_STROBE_PIN_OE_N(PROGRAM_STORE_STROBE_PIN_OE_N),
    .EXTERNAL_ACCESS_PIN(EXTERNAL_ACCESS_PIN), .ADDR_LATCH_PIN(ADDR_LATCH_PIN), .CORE_STROBE(CORE_STROBE),
    .CFG_RD(CFG_RD), .CFG_WR(CFG_WR), .CFG_SEL(CFG_SEL), .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA),
    .CFG_RDATA(CFG_RDATA), .PARALLEL_MODE(PARALLEL_MODE), .PARALLEL_ERASE(PARALLEL_ERASE),
    .ISP_ERASE(ISP_ERASE), .BOOT_SPACE_ENABLE(BOOT_SPACE_ENABLE), .FLASH_CONTROL(FLASH_CONTROL),
    .START_PC(START_PC), .DOUBLE_SPEED_SELECT(DOUBLE_SPEED_SELECT), .LOCK_FIELD(LOCK_FIELD),
    .FETCH_ENABLE(FETCH_ENABLE));
  rbs_board rbs_board_i (.clk(CLK), .srst(SRST), .strap(strap), .oe_n(PROGRAM_STORE_STROBE_PIN_OE_N),
    .o(PROGRAM_STORE_STROBE_PIN_O), .program_store_strobe_pin(PROGRAM_STORE_STROBE_PIN_I), .ea(EXTERNAL_ACCESS_PIN), .ale(ADDR_LATCH_PIN));
  initial forever #2 CLK = ~CLK;
  // Compare one value
  task chk(input [15:0] g, input [15:0] e);
    begin
      n_checks++;
      if (g !== e)
      begin
        n_mismatch++;
        $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wr(input [1:0] s, input [7:0] a, input [7:0] d);
    begin
      @(posedge CLK) {CFG_WR, CFG_SEL, CFG_ADDR, CFG_WDATA} <= {1'h1, s, a, d};
      @(posedge CLK) CFG_WR <= 1'h0;
    end
  endtask
  task rd(input [1:0] s, input [7:0] a, input [7:0] e);
    begin
      @(posedge CLK) {CFG_RD, CFG_SEL, CFG_ADDR} <= {1'h1, s, a};
      @(posedge CLK) CFG_RD <= 1'h0;
      #1 chk(CFG_RDATA, e);
    end
  endtask
  // Reset with given straps, check fetch, enable, control, start
  task boot(input [2:0] st, input [9:0] e, input [15:0] pc);
    begin
      @(posedge CLK) {SRST, strap} <= {1'h1, st};
      repeat (2) @(posedge CLK);
      SRST <= 1'h0;
      repeat (3) @(posedge CLK);
      #1 chk({FETCH_ENABLE, BOOT_SPACE_ENABLE, FLASH_CONTROL}, e);
      chk(START_PC, pc);
      chk({PROGRAM_STORE_STROBE_PIN_OE_N, PROGRAM_STORE_STROBE_PIN_I}, {1'h0, CORE_STROBE});
      $display("boot test done");
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial
  begin
    boot(3'h7, 10'h2F0, 16'hF800);
    rd(2'h1, 8'h00, 8'hB0);
    rd(2'h2, 8'h00, 8'hFC);
    rd(2'h0, 8'h61, 8'h44);
    rd(2'h0, 8'h32, 8'h00);
    wr(2'h0, 8'h30, 8'h00);
    rd(2'h0, 8'h30, 8'h11);
    @(posedge CLK) CE <= 1'h0;
    wr(2'h2, 8'h00, 8'h5A);
    @(posedge CLK) CE <= 1'h1;
    rd(2'h2, 8'h00, 8'hFC);
    wr(2'h1, 8'h00, 8'hC5);
    rd(2'h1, 8'h00, 8'hC0);
    chk({DOUBLE_SPEED_SELECT, LOCK_FIELD}, 16'h7);
    @(posedge CLK) CORE_STROBE <= 1'h1;
    boot(3'h7, 10'h3F0, 16'h0000);
    boot(3'h3, 10'h300, 16'hF800);
    boot(3'h2, 10'h3F0, 16'h0000);
    @(posedge CLK) PARALLEL_MODE <= 1'h1;
    wr(2'h1, 8'h00, 8'h42);
    rd(2'h1, 8'h00, 8'h42);
    chk({DOUBLE_SPEED_SELECT, LOCK_FIELD}, 16'hA);
    @(posedge CLK) ISP_ERASE <= 1'h1;
    @(posedge CLK) ISP_ERASE <= 1'h0;
    rd(2'h1, 8'h00, 8'h42);
    @(posedge CLK) PARALLEL_ERASE <= 1'h1;
    @(posedge CLK) PARALLEL_ERASE <= 1'h0;
    rd(2'h1, 8'h00, 8'hFF);
    @(posedge CLK) PARALLEL_MODE <= 1'h0;
    boot(3'h1, 10'h3F0, 16'h0000);
    wr(2'h1, 8'h00, 8'h3F);
    boot(3'h7, 10'h2F0, 16'hF800);
    results;
  end
  initial
  begin
    #20000;
    n_mismatch++;
    results;
  end
endmodule

//--- rbs_reset_boot_selection_monitor.sv
// Checker on the boot selection top module ports.
// Assumes CLK edges with SRST synchronous, active high.
`timescale 1ns/10ps
module rbs_mon (
  input wire CLK,
  input wire SRST,
  input wire PROGRAM_STORE_STROBE_PIN_I,
  input wire EXTERNAL_ACCESS_PIN,
  input wire ADDR_LATCH_PIN,
  input wire CFG_WR,
  input wire PARALLEL_MODE,
  input wire PARALLEL_ERASE,
  input wire PROGRAM_STORE_STROBE_PIN_OE_N,
  input wire BOOT_SPACE_ENABLE,
  input wire [7:0] FLASH_CONTROL,
  input wire [15:0] START_PC,
  input wire [2:0] LOCK_FIELD,
  input wire FETCH_ENABLE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // Strap combination that forces the loader
  wire forced = !PROGRAM_STORE_STROBE_PIN_I && EXTERNAL_ACCESS_PIN && ADDR_LATCH_PIN;
  fetch_wait_a: assert property ($fell(SRST) |-> !FETCH_ENABLE[*2] ##1 FETCH_ENABLE)
    else $error("fetch timing wrong");
  forced_boot_a: assert property ($fell(SRST) && forced |-> ##2 FLASH_CONTROL == 8'h00 && START_PC == 16'hF800)
    else $error("forced boot wrong");
  normal_ctrl_a: assert property ($fell(SRST) && !forced |-> ##2 FLASH_CONTROL == 8'hF0)
    else $error("flash control wrong");
  normal_pc_a: assert property ($fell(SRST) && !forced |-> ##2 START_PC == (BOOT_SPACE_ENABLE ? 16'h0000 : 16'hF800))
    else $error("start address wrong");
  boot_hold_a: assert property (FETCH_ENABLE |=> $stable(START_PC) && $stable(FLASH_CONTROL))
    else $error("boot state moved");
  pin_release_a: assert property (!FETCH_ENABLE |-> PROGRAM_STORE_STROBE_PIN_OE_N)
    else $error("strobe driven early");
  lock_keep_a: assert property (!CFG_WR && !PARALLEL_ERASE |=> $stable(LOCK_FIELD))
    else $error("lock field changed");
  lock_guard_a: assert property (!PARALLEL_MODE |=> $stable(LOCK_FIELD))
    else $error("lock reached by software");
endmodule
bind rbs_reset_boot_selection rbs_mon rbs_mon_i (
  .CLK(CLK),
  .SRST(SRST),
  .PROGRAM_STORE_STROBE_PIN_I(PROGRAM_STORE_STROBE_PIN_I),
  .EXTERNAL_ACCESS_PIN(EXTERNAL_ACCESS_PIN),
  .ADDR_LATCH_PIN(ADDR_LATCH_PIN),
  .CFG_WR(CFG_WR),
  .PARALLEL_MODE(PARALLEL_MODE),
  .PARALLEL_ERASE(PARALLEL_ERASE),
  .PROGRAM_STORE_STROBE_PIN_OE_N(PROGRAM_STORE_STROBE_PIN_OE_N),
  .BOOT_SPACE_ENABLE(BOOT_SPACE_ENABLE),
  .FLASH_CONTROL(FLASH_CONTROL),
  .START_PC(START_PC),
  .LOCK_FIELD(LOCK_FIELD),
  .FETCH_ENABLE(FETCH_ENABLE)
);

//--- rbs_strap_sampler.v
// Strap sampler: captures strap pins at reset release.
// Assumes pins are synchronous to CLK.
`timescale 1ns/10ps
module rbs_strap_sampler (
  input wire clk,
  input wire srst,
  input wire ce,
  input wire store_strobe_in,
  input wire ext_access_in,
  input wire addr_latch_in,
  output reg forced_boot_r,
  output reg release_pulse_r
);
  reg srst_d_r; // Reset delayed one cycle

  // Falling edge of reset detected; straps caught only then
  always @(posedge clk)
  begin
    if (ce)
    begin
      srst_d_r <= srst;
      release_pulse_r <= srst_d_r & ~srst;
      if (srst)
        forced_boot_r <= 1'b0;
      else if (srst_d_r)
        // Strap low, access high, latch high or floating
        forced_boot_r <= ~store_strobe_in & ext_access_in & addr_latch_in;
    end
  end
endmodule
